//--- verilog/temp_sensor_params.svh
`ifndef TEMP_SENSOR_PARAMS_SVH
`define TEMP_SENSOR_PARAMS_SVH
`define PTR_TEMPERATURE 2'h0
`define PTR_CONFIGURATION 2'h1
`define PTR_UPPER_LIMIT 2'h2
`define PTR_LOWER_LIMIT 2'h3
`define CFG_POWERDOWN 7
`define CFG_FILTER 6
`define CFG_ALERT_DISABLE 5
`define CFG_ALERT_POLARITY 4
`define CFG_ALERT_RESET 3
`define CFG_ONE_SHOT 2
`define CFG_RESET 8'h40
`define UPPER_RESET 8'h7F
`define LOWER_RESET 8'h80
`define ADDR_FIXED 4'h9
`define FILTER_LEN 3
`endif

//--- verilog/temp_sensor_pkg.sv
package temp_sensor_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ = 5'h08,
    ST_IGNORE = 5'h10
  } bus_state_t;
endpackage

//--- verilog/line_sync.sv
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
// Three-stage synchroniser with an optional glitch filter behind it.
module line_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line
  input wire logic line_in,
  input wire logic filter_en,
  output logic line_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [`FILTER_LEN-1:0] hist_r;
  logic out_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      hist_r <= '1;
      out_r <= 1'b1;
    end else begin
      s1_r <= line_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      hist_r <= {hist_r[`FILTER_LEN-2:0], s3_r};
      if (s2_r == s3_r) begin
        if (!filter_en) begin
          out_r <= s3_r;
        end else if (&{hist_r, s3_r} || ~|{hist_r, s3_r}) begin
          out_r <= s3_r;
        end
      end
    end
  end

  assign line_out = out_r;
endmodule

//--- verilog/temp_sensor_i2c_register_slave.sv
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
// Function
// - Eight-bit read/write configuration register at pointer one.
// - Bit seven set means full power-down; serial interface keeps running.
// - Bit six clear bypasses line glitch filtering; set keeps it.
// - Bit five set holds the over-temperature output inactive.
// - Bit four picks output polarity: zero low-active, one high-active.
// - Writing one to bit three clears the alert; reads zero.
// - Writing one to bit two starts one conversion; reads zero.
// - One-shot in power-down does one conversion, then stays powered down.
// - Read-only ten-bit two's-complement temperature at pointer zero, two bytes.
// - First byte holds upper eight bits; second byte bits seven, six.
// - Second byte bit five alert, four above, three below, rest zero.
// - Above-limit flag sets on exceed, clears on second byte read.
// - Below-limit flag sets under limit, clears on second byte read.
// - Upper limit register at pointer two; alert fires above it.
// - Lower limit register at pointer three; alert clears below it.
// - Bus address upper four bits 1001, lower bits from select pin.
// - After START shift in seven address bits and direction bit.
// - Matching address is acknowledged on the ninth clock.
// - Direction is fixed per transfer; a new START changes it.
// - Pointer-only write updates the pointer and no data register.
// - Reset gives pointer zero, limits 7F and 80, config 40.
// - Only the two pointer LSBs select a register.
// - Repeated reads use the stored pointer.
// - A result arriving during a serial access is discarded.
module temp_sensor_i2c_register_slave #(
  parameter logic [2:0] ADDR_LOW = 3'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address selection
  input wire logic [1:0] address_select_pin,
  // Converter
  input wire logic result_valid,
  input wire logic [9:0] result_value,
  output logic conv_start,
  output logic powered_down,
  // Over-temperature output
  output logic alert_out
);
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic [7:0] cfg_r;
  logic [7:0] upper_limit_r;
  logic [7:0] lower_limit_r;
  logic [9:0] temp_r;
  logic [1:0] ptr_r;
  logic above_limit_flag_r;
  logic below_limit_flag_r;
  logic alert_r;
  logic alert_out_r;
  logic sda_oe_n_r;
  logic conv_start_r;
  logic pd_r;
  logic busy_conv_r;
  temp_sensor_pkg::bus_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic byte_idx_r;
  logic got_ptr_r;
  logic rd_second_r;
  logic acking_r;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic [6:0] own_addr;
  logic wr_byte;
  logic [7:0] wr_data;
  logic above_now;
  logic below_now;
  logic [7:0] rd_byte;
  logic result_take;
  logic sda_out_r;

  line_sync scl_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .line_in(scl_in),
    .filter_en(cfg_r[`CFG_FILTER]),
    .line_out(scl_s)
  );
  line_sync sda_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .line_in(sda_in),
    .filter_en(cfg_r[`CFG_FILTER]),
    .line_out(sda_s)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
  // The two-bit select pin, XORed with ADDR_LOW, picks one of four low three-bit codes.
  assign own_addr = {`ADDR_FIXED, ADDR_LOW[2] ^ address_select_pin[1],
    ADDR_LOW[1:0] ^ address_select_pin};

  // Byte engine: samples data on SCL rise, drives on SCL fall.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= temp_sensor_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      byte_idx_r <= 1'b0;
      got_ptr_r <= 1'b0;
      acking_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      tx_r <= 8'h00;
    end else if (start_ev) begin
      state_r <= temp_sensor_pkg::ST_ADDR;
      bit_cnt_r <= 4'h0;
      acking_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_ev) begin
      state_r <= temp_sensor_pkg::ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      if (scl_rise && bit_cnt_r < 4'h8) begin
        shift_r <= {shift_r[6:0], sda_s};
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      end else if (scl_rise && bit_cnt_r == 4'h8) begin
        bit_cnt_r <= 4'h9;
        if (state_r == temp_sensor_pkg::ST_READ && sda_s) begin
          state_r <= temp_sensor_pkg::ST_IGNORE;
        end
      end
      if (scl_fall && bit_cnt_r == 4'h8) begin
        case (state_r)
          temp_sensor_pkg::ST_ADDR: begin
            if (shift_r[7:1] == own_addr) begin
              sda_oe_n_r <= 1'b0;
              acking_r <= 1'b1;
              byte_idx_r <= 1'b0;
              got_ptr_r <= 1'b0;
              tx_r <= rd_byte;
              state_r <= shift_r[0] ? temp_sensor_pkg::ST_READ
                : temp_sensor_pkg::ST_WRITE;
            end else begin
              state_r <= temp_sensor_pkg::ST_IGNORE;
            end
          end
          temp_sensor_pkg::ST_WRITE: begin
            sda_oe_n_r <= 1'b0;
            acking_r <= 1'b1;
            got_ptr_r <= 1'b1;
          end
          temp_sensor_pkg::ST_READ: begin
            sda_oe_n_r <= 1'b1;
          end
          default: begin
            sda_oe_n_r <= 1'b1;
          end
        endcase
      end else if (scl_fall && bit_cnt_r == 4'h9) begin
        bit_cnt_r <= 4'h0;
        acking_r <= 1'b0;
        if (state_r == temp_sensor_pkg::ST_READ) begin
          if (!acking_r) begin
            byte_idx_r <= 1'b1;
            tx_r <= {temp_r[1:0], alert_r, above_limit_flag_r,
              below_limit_flag_r, 3'h0};
          end
          sda_oe_n_r <= acking_r ? tx_r[7] : 1'b1;
          tx_r <= acking_r ? {tx_r[6:0], 1'b0} : rd_byte;
          if (!acking_r) begin
            sda_oe_n_r <= byte_idx_r ? rd_byte[7] : temp_r[1];
            tx_r <= byte_idx_r ? {rd_byte[6:0], 1'b0}
              : {temp_r[0], alert_r, above_limit_flag_r,
                below_limit_flag_r, 4'h0};
          end
        end else begin
          sda_oe_n_r <= 1'b1;
        end
      end else if (scl_fall && state_r == temp_sensor_pkg::ST_READ) begin
        sda_oe_n_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Read data is open drain: a one releases the line.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_second_r <= 1'b0;
    end else begin
      rd_second_r <= scl_fall && bit_cnt_r == 4'h9 && !acking_r
        && state_r == temp_sensor_pkg::ST_READ && !byte_idx_r
        && ptr_r == `PTR_TEMPERATURE;
    end
  end

  // Byte read is the pointed register; temperature gives its upper part.
  always_comb begin
    case (ptr_r)
      `PTR_TEMPERATURE: rd_byte = temp_r[9:2];
      `PTR_CONFIGURATION: rd_byte = {cfg_r[7:4], 2'h0, cfg_r[1:0]};
      `PTR_UPPER_LIMIT: rd_byte = upper_limit_r;
      `PTR_LOWER_LIMIT: rd_byte = lower_limit_r;
      default: rd_byte = 8'h00;
    endcase
  end

  assign wr_byte = scl_fall && bit_cnt_r == 4'h8
    && state_r == temp_sensor_pkg::ST_WRITE;
  assign wr_data = shift_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_r <= `PTR_TEMPERATURE;
    end else if (wr_byte && !got_ptr_r) begin
      ptr_r <= wr_data[1:0];
    end
  end

  // Self-clearing bits three and two are never stored.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= `CFG_RESET;
      upper_limit_r <= `UPPER_RESET;
      lower_limit_r <= `LOWER_RESET;
    end else if (wr_byte && got_ptr_r) begin
      case (ptr_r)
        `PTR_CONFIGURATION: cfg_r <= {wr_data[7:4], 2'h0, wr_data[1:0]};
        `PTR_UPPER_LIMIT: upper_limit_r <= wr_data;
        `PTR_LOWER_LIMIT: lower_limit_r <= wr_data;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // Conversion control; the serial side keeps running in power-down.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_start_r <= 1'b0;
      busy_conv_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      conv_start_r <= wr_byte && got_ptr_r && ptr_r == `PTR_CONFIGURATION
        && wr_data[`CFG_ONE_SHOT];
      if (conv_start_r) begin
        busy_conv_r <= 1'b1;
      end else if (result_valid) begin
        busy_conv_r <= 1'b0;
      end
      pd_r <= cfg_r[`CFG_POWERDOWN] && !busy_conv_r && !conv_start_r;
    end
  end

  // Results during any serial access are dropped to avoid torn reads.
  assign result_take = result_valid
    && state_r == temp_sensor_pkg::ST_IDLE;
  assign above_now = $signed(result_value[9:2]) > $signed(upper_limit_r);
  assign below_now = $signed(result_value[9:2]) < $signed(lower_limit_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_r <= 10'h000;
    end else if (result_take) begin
      temp_r <= result_value;
    end
  end

  // Set wins over the read clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      above_limit_flag_r <= 1'b0;
      below_limit_flag_r <= 1'b0;
    end else begin
      above_limit_flag_r <= (result_take && above_now)
        || (above_limit_flag_r && !rd_second_r);
      below_limit_flag_r <= (result_take && below_now)
        || (below_limit_flag_r && !rd_second_r);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_r <= 1'b0;
    end else if (cfg_r[`CFG_ALERT_DISABLE]) begin
      alert_r <= 1'b0;
    end else if (result_take && above_now) begin
      alert_r <= 1'b1;
    end else if (result_take && below_now) begin
      alert_r <= 1'b0;
    end else if (wr_byte && got_ptr_r && ptr_r == `PTR_CONFIGURATION
        && wr_data[`CFG_ALERT_RESET]) begin
      alert_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_out_r <= 1'b1;
    end else begin
      alert_out_r <= alert_r ~^ cfg_r[`CFG_ALERT_POLARITY];
    end
  end

  // The data pin is open drain, so its driven level is always low.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe_n = sda_oe_n_r;
  assign conv_start = conv_start_r;
  assign powered_down = pd_r;
  assign alert_out = alert_out_r;
endmodule

//--- verif/temp_sensor_sva.sv
`timescale 1ns/1ps
// Port checker; SDA timing is judged against the raw clock pin.
module temp_sensor_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic conv_start,
  input wire logic powered_down,
  input wire logic alert_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rst_values: assert property ($fell(sys_rst) |-> alert_out
    && !conv_start && !powered_down) else $error("reset outputs");
  a_rel_quiet: assert property ($fell(sys_rst) |-> sda_oe_n [*6])
    else $error("bus driven after reset");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("low drive too short");
  a_sda_low_phase: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data moved while clock high");
  a_start_quiet: assert property ($fell(sda_in) && scl_in
    |=> sda_oe_n [*8]) else $error("driven during address");
  a_conv_single: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_conv_wakes: assert property (conv_start |=> !powered_down)
    else $error("asleep with conversion pending");
  cover property (conv_start);
  cover property ($rose(powered_down));
  cover property ($fell(alert_out));
  cover property ($fell(sda_oe_n));
endmodule
bind temp_sensor_i2c_register_slave temp_sensor_sva chk_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .conv_start(conv_start),
  .powered_down(powered_down),
  .alert_out(alert_out)
);

//--- verif/i2c_master_model.sv
`timescale 1ns/1ps
// Bus master; SDA is released to the pull-up, SCL idles high between frames.
module i2c_master_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Halves are kept long because the target filters and syncs the pins.
  task automatic q();
    repeat (6) @(posedge clk);
  endtask
  task automatic start();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    // The target sees STOP only after its filter settles; wait it out.
    q();
    q();
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_drv <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Eight bits MSB first, then the acknowledge slot.
  task automatic byte9(input logic [7:0] d, input logic a,
                       output logic [7:0] r, output logic ak);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], x);
      r[i] = x;
    end
    bitx(a, ak);
  endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
`include "temp_sensor_params.svh"
module tb;
  localparam logic [6:0] DEV = {`ADDR_FIXED, 3'h0};
  logic clk, sys_rst, scl, sda_drv, result_valid, sda_out, sda_oe_n;
  logic conv_start, powered_down, alert_out, ak;
  logic [9:0] result_value;
  logic [1:0] address_select_pin;
  logic [7:0] b0, b1, rb;
  logic [7:0] n_cs = 8'h00;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire sda = sda_drv & (sda_oe_n | sda_out);
  i2c_master_model mst (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  temp_sensor_i2c_register_slave dut (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pin(address_select_pin), .result_valid(result_valid),
    .result_value(result_value), .conv_start(conv_start),
    .powered_down(powered_down), .alert_out(alert_out));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (conv_start === 1'b1) n_cs <= n_cs + 8'h01;
    cyc++;
    if (cyc > 60000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input int n, input logic [7:0] d);
    mst.start();
    mst.byte9({DEV, 1'b0}, 1'b1, rb, ak);
    chk({7'h0, ak}, 8'h00);
    mst.byte9(p, 1'b1, rb, ak);
    if (n > 0) mst.byte9(d, 1'b1, rb, ak);
    mst.stop();
  endtask
  task automatic rd(input int n);
    mst.start();
    mst.byte9({DEV, 1'b1}, 1'b1, rb, ak);
    mst.byte9(8'hFF, n == 1, b0, ak);
    if (n > 1) mst.byte9(8'hFF, 1'b1, b1, ak);
    mst.stop();
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    wr(p, 0, 8'h00);
    rd(1);
    chk(b0, e);
  endtask
  // The result is held one cycle only, as a real converter would.
  task automatic conv(input logic [9:0] v);
    result_value <= v;
    result_valid <= 1'b1;
    @(posedge clk);
    result_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    sys_rst = 1'b1;
    result_valid = 1'b0;
    result_value = 10'h000;
    address_select_pin = 2'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    rreg(8'hFD, 8'h40);
    rreg(8'hFE, 8'h7F);
    rreg(8'hFF, 8'h80);
    mst.start();
    mst.byte9(8'hB0, 1'b1, rb, ak);
    chk({7'h0, ak}, 8'h01);
    mst.stop();
    $display("test defaults done");
    wr(8'h02, 1, 8'h19);
    wr(8'h03, 1, 8'h14);
    wr(8'h01, 1, 8'h5C);
    chk(n_cs, 8'h01);
    rreg(8'h01, 8'h50);
    rreg(8'h02, 8'h19);
    rd(1);
    chk(b0, 8'h19);
    $display("test registers done");
    conv(10'h068);
    chk({7'h0, alert_out}, 8'h01);
    wr(8'h00, 0, 8'h00);
    rd(2);
    chk(b0, 8'h1A);
    chk(b1, 8'h30);
    rd(2);
    chk(b1, 8'h20);
    conv(10'h04C);
    chk({7'h0, alert_out}, 8'h00);
    rd(2);
    chk(b0, 8'h13);
    chk(b1, 8'h08);
    $display("test limits done");
    conv(10'h068);
    wr(8'h01, 1, 8'h58);
    chk({7'h0, alert_out}, 8'h00);
    conv(10'h068);
    chk({7'h0, alert_out}, 8'h01);
    wr(8'h01, 1, 8'h70);
    conv(10'h068);
    chk({7'h0, alert_out}, 8'h00);
    wr(8'h01, 1, 8'h40);
    conv(10'h04C);
    chk({7'h0, alert_out}, 8'h01);
    conv(10'h068);
    chk({7'h0, alert_out}, 8'h00);
    $display("test alert done");
    mst.start();
    mst.byte9({DEV, 1'b0}, 1'b1, rb, ak);
    conv(10'h0C8);
    mst.byte9(8'h00, 1'b1, rb, ak);
    mst.stop();
    rd(2);
    chk(b0, 8'h1A);
    wr(8'h01, 1, 8'h00);
    rreg(8'h01, 8'h00);
    wr(8'h01, 1, 8'hC0);
    chk({7'h0, powered_down}, 8'h01);
    wr(8'h01, 1, 8'hC4);
    chk(n_cs, 8'h02);
    chk({7'h0, powered_down}, 8'h00);
    conv(10'h070);
    chk({7'h0, powered_down}, 8'h01);
    wr(8'h00, 0, 8'h00);
    rd(2);
    chk(b0, 8'h1C);
    $display("test power done");
    test_done();
  end
endmodule
